// ### test_up_down_counter_4bit.sv
// Self-checking bench for udc_counter with a cascaded next stage.
// Assumes the binary variant at reset and Avalon slave with one wait cycle.
`timescale 1ns/1ps
module test_up_down_counter_4bit;
  import udc_pkg::*;
  logic clock, reset_n, countEnableN, countDown, loadN, terminalCount, rippleClockOutN;
  logic read, write, waitrequest;
  logic [3:0] presetData, countOut, address, byteenable, nextCount, s, n;
  logic [31:0] writedata, readdata, rd;
  logic d, t;
  int errors, checks;
  // Row fields: decade, start, down, next, terminal
  logic [10:0] rows [8] = '{11'h002, 11'h3C1, 11'h03F, 11'h22E, 11'h254,
    11'h641, 11'h433, 11'h54C};
  udc_counter dut_u (.clock, .reset_n, .countEnableN, .countDown, .loadN, .presetData,
    .countOut, .terminalCount, .rippleClockOutN, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest);
  udc_next_stage next_u (.reset_n(reset_n), .rippleN(rippleClockOutN), .count(nextCount));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Called just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    // Request stands until the rising edge that sees waitrequest low
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clock);
    errors++;
    test_done;
  end
  initial begin
    reset_n = 0; countEnableN = 1; countDown = 0; loadN = 1; presetData = 0;
    read = 0; write = 0; address = 0; writedata = 0; byteenable = 4'hF;
    repeat (2) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    check(countOut, 0);
    bus(0, UDC_OFS_CTRL, 0);
    check(rd, 0);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) begin
        @(posedge clock);
        bus(1, UDC_OFS_CTRL, 1);
        @(posedge clock);
        bus(0, UDC_OFS_CTRL, 0);
        check(rd, 1);
      end
      {s, d, n, t} = rows[i][9:0];
      @(posedge clock);
      loadN <= 0; presetData <= s; countDown <= d;
      @(negedge clock); check(countOut, s);
      @(posedge clock); loadN <= 1; countEnableN <= 0;
      @(negedge clock); check(terminalCount, t);
      @(posedge clock); countEnableN <= 1;
      @(negedge clock); check(countOut, n);
      @(posedge clock);
      @(negedge clock); check(countOut, n);
    end
    @(posedge clock);
    bus(0, 4'h2, 0);
    check(rd, 0);
    @(posedge clock);
    bus(0, UDC_OFS_STATUS, 0);
    check(rd[3:0], 4'h6);
    check(nextCount, 4'h4);
    // Hold at fifteen: terminal stands but no cascade pulse
    @(posedge clock);
    bus(1'b1, UDC_OFS_PRESET, 32'h0000_000F);
    @(posedge clock);
    bus(1'b1, UDC_OFS_CTRL, 32'h0000_0002);
    countEnableN <= 1'b0;
    @(negedge clock);
    #1;
    check(countOut, 4'hF);
    check(terminalCount, 1'b1);
    check(rippleClockOutN, 1'b1);
    @(posedge clock);
    @(negedge clock);
    check(countOut, 4'hF);
    @(posedge clock);
    bus(1'b1, UDC_OFS_CTRL, 32'h0000_0000);
    @(negedge clock);
    #1;
    check(rippleClockOutN, 1'b0);
    @(posedge clock);
    countEnableN <= 1'b1;
    @(negedge clock);
    check(countOut, 4'h0);
    check(nextCount, 4'h5);
    @(posedge clock);
    bus(1'b0, UDC_OFS_WRAPS, 32'h0000_0000);
    check(rd, 32'h0000_0005);
    @(posedge clock);
    bus(1'b1, UDC_OFS_WRAPS, 32'h0000_0000);
    @(posedge clock);
    bus(1'b0, UDC_OFS_WRAPS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    @(posedge clock);
    bus(1'b1, UDC_OFS_PRESET, 32'h0000_0007);
    // Reset in mid-run clears count, bus state and the next stage
    @(posedge clock);
    reset_n <= 1'b0;
    @(negedge clock);
    check(countOut, 4'h0);
    check(nextCount, 4'h0);
    check(waitrequest, 1'b1);
    @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, UDC_OFS_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    test_done;
  end
endmodule

// ### udc_counter.sv
// Synchronous reversible 4-bit counter, decade or binary, with cascade outputs.
// Assumes pins synchronous to clock; registers reached over Avalon-MM.
//
// How it works
// - All four count bits update on rising clock edge only when enable low and hold clear, or on load or a preset write.
// - Direction low counts up, high counts down, at each enabled edge.
// - Four bits wide; decade variant counts 0-9, binary variant 0-15.
// - Decade variant wraps nine to zero upward, zero to nine downward.
// - Binary variant wraps fifteen to zero upward, zero to fifteen downward.
// - All count bits change together from one clock, no ripple glitches.
// - Enable and direction changes affect count only at next clock edge.
// - Load low presets each count bit from its data input, clock independent.
// - While load is low the outputs follow data inputs without a clock.
// - Terminal count high at zero counting down or maximum counting up.
// - Ripple clock low on terminal count, while enable low and hold clear, only while the clock is low.
`timescale 1ns/1ps

module udc_counter
  import udc_pkg::*;
#(
  parameter bit DECADE = 1'b0
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic countEnableN,
  input wire logic countDown,
  input wire logic loadN,
  input wire logic [3:0] presetData,
  output logic [3:0] countOut,
  output logic terminalCount,
  output logic rippleClockOutN,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  udc_state_t st_reg;
  udc_state_t st_next;
  logic [3:0] stepCount;
  logic stepWrap;
  logic countActive;
  logic [3:0] liveCount;
  logic [3:0] maxCount;
  logic atTerminal;

  udc_step u_step (
    .count(st_reg.count),
    .countDown(countDown),
    .decadeSel(st_reg.decadeSel),
    .nextCount(stepCount),
    .wrapped(stepWrap)
  );

  function automatic logic [31:0] read_word(
    input logic [3:0] addr,
    input udc_state_t st,
    input logic [3:0] cnt,
    input logic term,
    input logic down,
    input logic loading,
    input logic active
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      UDC_OFS_CTRL: begin
        word[UDC_CTRL_DECADE] = st.decadeSel;
        word[UDC_CTRL_HOLD] = st.holdCount;
      end
      UDC_OFS_STATUS: begin
        word[UDC_STAT_COUNT_LSB +: 4] = cnt;
        word[UDC_STAT_TERMINAL] = term;
        word[UDC_STAT_DOWN] = down;
        word[UDC_STAT_LOADING] = loading;
        word[UDC_STAT_ENABLED] = active;
      end
      UDC_OFS_PRESET: begin
        word[3:0] = cnt;
      end
      UDC_OFS_WRAPS: begin
        word[15:0] = st.wraps;
      end
      default: begin
        word = 32'h0000_0000;
      end
    endcase
    return word;
  endfunction

  // Enable from the pin, further gated by the software hold bit
  assign countActive = !countEnableN && !st_reg.holdCount;

  // Load bypasses the flops so data shows without a clock edge
  assign liveCount = loadN ? st_reg.count : presetData;
  assign countOut = liveCount;

  assign maxCount = st_reg.decadeSel ? UDC_DEC_MAX : UDC_BIN_MAX;
  assign atTerminal = countDown ? (liveCount == UDC_ZERO) : (liveCount == maxCount);
  assign terminalCount = atTerminal;

  // Clock is used as data here on purpose: the pulse covers the low half only
  assign rippleClockOutN = !(atTerminal && countActive && !clock);

  assign readdata = st_reg.rdata;
  assign waitrequest = st_reg.waitReq;

  always_comb begin
    st_next = st_reg;

    // Count path; direction and enable are sampled only at the edge
    if (!loadN) begin
      st_next.count = presetData;
    end else if (countActive) begin
      st_next.count = stepCount;
      if (stepWrap) begin
        st_next.wraps = st_reg.wraps + UDC_WRAPS_ONE;
      end
    end

    // Bus: one wait cycle, then answer for one cycle
    if (st_reg.waitReq) begin
      if (read || write) begin
        st_next.waitReq = 1'b0;
        st_next.rdata = read ? read_word(address, st_reg, liveCount, atTerminal,
          countDown, !loadN, countActive) : UDC_RST_RDATA;
      end
    end else begin
      st_next.waitReq = 1'b1;
      if (write && byteenable[0]) begin
        case (address)
          UDC_OFS_CTRL: begin
            st_next.decadeSel = writedata[UDC_CTRL_DECADE];
            st_next.holdCount = writedata[UDC_CTRL_HOLD];
          end
          UDC_OFS_PRESET: begin
            // Pin load keeps priority over a software preset
            if (loadN) begin
              st_next.count = writedata[3:0];
            end
          end
          UDC_OFS_WRAPS: begin
            // A wrap in the clearing cycle is still counted
            st_next.wraps = (loadN && countActive && stepWrap) ? UDC_WRAPS_ONE : UDC_RST_WRAPS;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.count <= UDC_RST_COUNT;
      st_reg.decadeSel <= DECADE;
      st_reg.holdCount <= UDC_RST_HOLD;
      st_reg.wraps <= UDC_RST_WRAPS;
      st_reg.waitReq <= 1'b1;
      st_reg.rdata <= UDC_RST_RDATA;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ### udc_counter_chk.sv
// Pin-level assertions for udc_counter.
// Assumes hold is set only while the count rests at its maximum.
`timescale 1ns/1ps
module udc_counter_chk
  import udc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic countEnableN,
  input wire logic countDown,
  input wire logic loadN,
  input wire logic [3:0] presetData,
  input wire logic [3:0] countOut,
  input wire logic terminalCount,
  input wire logic rippleClockOutN,
  input wire logic [3:0] address,
  input wire logic write,
  input wire logic waitrequest
);
  wire run = loadN && !countEnableN;
  // Software preset lands at this edge
  wire presetWrite = write && !waitrequest && address == UDC_OFS_PRESET;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  count_hold_a: assert property (loadN && countEnableN && !presetWrite |=>
    !loadN || countOut == $past(countOut)) else $error("count moved");
  step_up_a: assert property (run && !countDown && countOut < 4'h9 |=>
    !loadN || countOut == $past(countOut) + 4'h1) else $error("bad up step");
  step_down_a: assert property (run && countDown && countOut inside {[4'h1:4'h9]} |=>
    !loadN || countOut == $past(countOut) - 4'h1) else $error("bad down step");
  wrap_down_a: assert property (run && countDown && countOut == 4'h0 |=>
    !loadN || countOut inside {4'h9, 4'hF}) else $error("bad down wrap");
  load_follow_a: assert property (!loadN |-> countOut == presetData)
    else $error("load not followed");
  term_level_a: assert property (terminalCount |->
    (countDown ? countOut == 4'h0 : countOut >= 4'h9)) else $error("bad terminal");
  term_zero_a: assert property (countDown && countOut == 4'h0 |-> terminalCount)
    else $error("missing terminal");
  ripple_cause_a: assert property (!rippleClockOutN |->
    terminalCount && !countEnableN) else $error("stray ripple");
  ripple_phase_a: assert property (@(negedge clock) rippleClockOutN)
    else $error("ripple in high phase");
  cover property (!rippleClockOutN);
  cover property (!loadN);
  cover property (terminalCount && countDown);
endmodule

bind udc_counter udc_counter_chk chk_u (.clock, .reset_n, .countEnableN, .countDown,
  .loadN, .presetData, .countOut, .terminalCount, .rippleClockOutN, .address, .write,
  .waitrequest);

// ### udc_next_stage.sv
// Following counter stage, clocked by the cascade output.
// Assumes enables are shared, so the ripple rising edge is its clock.
`timescale 1ns/1ps
module udc_next_stage (
  input wire logic reset_n,
  input wire logic rippleN,
  output logic [3:0] count
);
  // Reset swallows the power-up edge of the ripple pin
  always @(posedge rippleN or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end
endmodule

// ### udc_pkg.sv
// Constants and state type for the 4-bit up/down counter.
// Assumes a single 200 MHz clock and a 32-bit Avalon-MM register slave.
package udc_pkg;

  localparam int UDC_WIDTH = 4;

  // Count limits of the two variants
  localparam logic [3:0] UDC_DEC_MAX = 4'h9;
  localparam logic [3:0] UDC_BIN_MAX = 4'hF;
  localparam logic [3:0] UDC_ZERO = 4'h0;

  // Register byte offsets
  localparam logic [3:0] UDC_OFS_CTRL = 4'h0;
  localparam logic [3:0] UDC_OFS_STATUS = 4'h4;
  localparam logic [3:0] UDC_OFS_PRESET = 4'h8;
  localparam logic [3:0] UDC_OFS_WRAPS = 4'hC;

  // Control fields
  localparam int UDC_CTRL_DECADE = 0;
  localparam int UDC_CTRL_HOLD = 1;

  // Status fields
  localparam int UDC_STAT_COUNT_LSB = 0;
  localparam int UDC_STAT_TERMINAL = 4;
  localparam int UDC_STAT_DOWN = 5;
  localparam int UDC_STAT_LOADING = 6;
  localparam int UDC_STAT_ENABLED = 7;

  // Reset values and the wrap-count increment
  localparam logic [3:0] UDC_RST_COUNT = 4'h0;
  localparam logic UDC_RST_HOLD = 1'b0;
  localparam logic [15:0] UDC_RST_WRAPS = 16'h0000;
  localparam logic [15:0] UDC_WRAPS_ONE = 16'h0001;
  localparam logic [31:0] UDC_RST_RDATA = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] count;
    logic decadeSel;
    logic holdCount;
    logic [15:0] wraps;
    logic waitReq;
    logic [31:0] rdata;
  } udc_state_t;

endpackage

// ### udc_step.sv
// Next-count logic of the up/down counter, purely combinational.
// Assumes the caller registers the result on its own clock.
`timescale 1ns/1ps

module udc_step
  import udc_pkg::*;
(
  input wire logic [3:0] count,
  input wire logic countDown,
  input wire logic decadeSel,
  output logic [3:0] nextCount,
  output logic wrapped
);

  logic [3:0] maxCount;

  always_comb begin
    maxCount = decadeSel ? UDC_DEC_MAX : UDC_BIN_MAX;
    if (countDown) begin
      if (count == UDC_ZERO) begin
        nextCount = maxCount;
        wrapped = 1'b1;
      end else begin
        nextCount = count - 4'h1;
        wrapped = 1'b0;
      end
    end else begin
      // Out-of-range decade values fold to zero rather than running on
      if (count >= maxCount) begin
        nextCount = UDC_ZERO;
        wrapped = 1'b1;
      end else begin
        nextCount = count + 4'h1;
        wrapped = 1'b0;
      end
    end
  end

endmodule
